// ### tct_pkg.sv
/*
 * Constants shared by the two-channel timer core: widths, reset values,
 * prescaler codes and channel edge/level select encodings.
 * Assumes a single synchronous clock domain and no register bus.
 */
`default_nettype none
package tct_pkg;

    localparam int unsigned CNT_W       = 16;
    localparam int unsigned BYTE_W      = 8;
    localparam int unsigned CH_N        = 2;
    localparam int unsigned PS_W        = 3;
    localparam int unsigned PRESC_W     = 6;
    localparam int unsigned SEL_W       = 2;

    // Value of the counter, the wrap value and the flags after reset.
    localparam logic [CNT_W-1:0]  CNT_RESET  = 16'h0000;
    localparam logic [BYTE_W-1:0] WRAP_RESET = 8'hFF;
    localparam logic [PS_W-1:0]   PS_RESET   = 3'h0;
    localparam logic [PRESC_W-1:0] PRESC_RESET = 6'h00;
    localparam logic              HALT_RESET = 1'b1;
    localparam logic              FLAG_RESET = 1'b0;

    // Prescale selection above this code has no division ratio.
    localparam logic [PS_W-1:0]   PS_LAST    = 3'h6;

    // Edge and level select: 00 returns the pin to the port.
    localparam logic [SEL_W-1:0]  SEL_PORT   = 2'h0;
    localparam logic [SEL_W-1:0]  SEL_RISE   = 2'h1;
    localparam logic [SEL_W-1:0]  SEL_FALL   = 2'h2;
    localparam logic [SEL_W-1:0]  SEL_ANY    = 2'h3;
    localparam logic [SEL_W-1:0]  SEL_TOGGLE = 2'h1;
    localparam logic [SEL_W-1:0]  SEL_CLEAR  = 2'h2;
    localparam logic [SEL_W-1:0]  SEL_SET    = 2'h3;

    // Index of the channel that leads a buffered pair.
    localparam int unsigned       CH_LEAD    = 0;

endpackage
`default_nettype wire

// ### tct_core.sv
/*
 * Two-channel timer core: prescaled 16-bit up-counter with modulo wrap,
 * and two channels for input capture, output compare and PWM.
 * Assumes control bits arrive as same-clock ports from the host logic and
 * channel pins arrive asynchronously from outside the chip.
 */
// Summary of operation
// - 16-bit counter, free-running or modulo wrap.
// - Wrap value from high and low bytes.
// - Counter readable anytime without disturbing counting.
// - Each channel independently capture or compare.
// - Capture on rising, falling or any edge.
// - Compare match sets, clears or toggles pin.
// - Unbuffered and buffered PWM output generation.
// - Counter clock: bus clock, seven prescale ratios.
// - Channel pin may toggle on overflow.
// - Halt bit stops; clear bit zeroes counter, prescaler.
// - One shared counter times both channels.
// - Pins shared with port; timer takes over.
// - Reset: flags, prescaler count cleared; halt, enable, prescale select from host ports.
// - Reset: wrap all ones, counter zero.
`timescale 1ns/1ps
`default_nettype none
module tct_core
    import tct_pkg::*;
(
    input  wire logic                              ref_clk,
    input  wire logic                              rst,
    input  wire logic                              counterHalt,
    input  wire logic                              counterClear,
    input  wire logic [tct_pkg::PS_W-1:0]          prescaleSel,
    input  wire logic                              overflowIrqEnable,
    input  wire logic                              overflowFlagClear,
    input  wire logic [tct_pkg::BYTE_W-1:0]        wrapValueHighIn,
    input  wire logic                              wrapValueHighWrite,
    input  wire logic [tct_pkg::BYTE_W-1:0]        wrapValueLowIn,
    input  wire logic                              wrapValueLowWrite,
    output logic [tct_pkg::CNT_W-1:0]              counterValue,
    output logic [tct_pkg::BYTE_W-1:0]             wrapValueHigh,
    output logic [tct_pkg::BYTE_W-1:0]             wrapValueLow,
    output logic                                   counterHaltBit,
    output logic                                   overflowFlag,
    output logic                                   overflowIrq,
    input  wire logic                              bufferedPwm,
    input  wire logic [tct_pkg::CH_N-1:0]          chCompareMode,
    input  wire logic [tct_pkg::CH_N*2-1:0]        chEdgeLevelSel,
    input  wire logic [tct_pkg::CH_N-1:0]          chToggleOnOverflow,
    input  wire logic [tct_pkg::CH_N-1:0]          chMaxDuty,
    input  wire logic [tct_pkg::CH_N*16-1:0]       chValueIn,
    input  wire logic [tct_pkg::CH_N-1:0]          chValueWrite,
    input  wire logic [tct_pkg::CH_N-1:0]          chFlagClear,
    output logic [tct_pkg::CH_N*16-1:0]            chValue,
    output logic [tct_pkg::CH_N-1:0]               chFlag,
    input  wire logic [tct_pkg::CH_N-1:0]          portOut,
    input  wire logic [tct_pkg::CH_N-1:0]          portOe_n,
    input  wire logic [tct_pkg::CH_N-1:0]          chPinIn,
    output logic [tct_pkg::CH_N-1:0]               chPinOut,
    output logic [tct_pkg::CH_N-1:0]               chPinOe_n
);
    import tct_pkg::*;
    logic [CNT_W-1:0]   count_r;
    logic [CNT_W-1:0]   count_nxt;
    logic [PRESC_W-1:0] presc_r;
    logic [PRESC_W-1:0] presc_nxt;
    logic [BYTE_W-1:0]  wrapHi_r;
    logic [BYTE_W-1:0]  wrapHi_nxt;
    logic [BYTE_W-1:0]  wrapLo_r;
    logic [BYTE_W-1:0]  wrapLo_nxt;
    logic               ovf_r;
    logic               ovf_nxt;
    logic               irq_r;
    logic               irq_nxt;
    logic               tickDone_r;
    logic               tickDone_nxt;
    logic               ovfEvent_r;
    logic               ovfEvent_nxt;
    logic               lastWrOne_r;
    logic               lastWrOne_nxt;
    logic               bufSel_r;
    logic               bufSel_nxt;
    logic               tick;
    logic               wrapHit;
    logic [CNT_W-1:0]   wrapValue;
    logic [PRESC_W-1:0] prescMask;
    logic [CNT_W-1:0]   chReg_r [CH_N];

    assign wrapValue      = {wrapHi_r, wrapLo_r};
    assign counterValue   = count_r;
    assign wrapValueHigh  = wrapHi_r;
    assign wrapValueLow   = wrapLo_r;
    assign counterHaltBit = counterHalt;
    assign overflowFlag   = ovf_r;
    assign overflowIrq    = irq_r;

    // Prescaler taps a power-of-two ratio from 1 to 64.
    always_comb begin
        prescMask = PRESC_W'((7'h01 << prescaleSel) - 7'h01);
        tick      = (prescaleSel <= PS_LAST) && !counterHalt
                    && ((presc_r & prescMask) == prescMask);
        wrapHit   = tick && (count_r == wrapValue);
    end

    always_comb begin
        count_nxt     = count_r;
        presc_nxt     = presc_r;
        wrapHi_nxt    = wrapHi_r;
        wrapLo_nxt    = wrapLo_r;
        ovf_nxt       = ovf_r;
        ovfEvent_nxt  = wrapHit;
        tickDone_nxt  = tick;
        lastWrOne_nxt = lastWrOne_r;
        bufSel_nxt    = bufSel_r;
        if (!counterHalt) begin
            presc_nxt = PRESC_W'(presc_r + 6'h01);
        end
        if (wrapHit) begin
            count_nxt = CNT_RESET;
        end else if (tick) begin
            count_nxt = CNT_W'(count_r + 16'h0001);
        end
        if (counterClear) begin
            count_nxt = CNT_RESET;
            presc_nxt = PRESC_RESET;
        end
        if (wrapValueHighWrite) begin
            wrapHi_nxt = wrapValueHighIn;
        end
        if (wrapValueLowWrite) begin
            wrapLo_nxt = wrapValueLowIn;
        end
        if (overflowFlagClear) begin
            ovf_nxt = 1'b0;
        end
        if (wrapHit) begin
            ovf_nxt = 1'b1;
        end
        irq_nxt = ovf_nxt && overflowIrqEnable;
        // Buffered PWM: the register written last takes over at overflow.
        if (chValueWrite[1]) begin
            lastWrOne_nxt = 1'b1;
        end else if (chValueWrite[0]) begin
            lastWrOne_nxt = 1'b0;
        end
        if (wrapHit) begin
            bufSel_nxt = lastWrOne_nxt;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            count_r     <= CNT_RESET;
            presc_r     <= PRESC_RESET;
            wrapHi_r    <= WRAP_RESET;
            wrapLo_r    <= WRAP_RESET;
            ovf_r       <= FLAG_RESET;
            irq_r       <= FLAG_RESET;
            tickDone_r  <= 1'b0;
            ovfEvent_r  <= 1'b0;
            lastWrOne_r <= 1'b0;
            bufSel_r    <= 1'b0;
        end else begin
            count_r     <= count_nxt;
            presc_r     <= presc_nxt;
            wrapHi_r    <= wrapHi_nxt;
            wrapLo_r    <= wrapLo_nxt;
            ovf_r       <= ovf_nxt;
            irq_r       <= irq_nxt;
            tickDone_r  <= tickDone_nxt;
            ovfEvent_r  <= ovfEvent_nxt;
            lastWrOne_r <= lastWrOne_nxt;
            bufSel_r    <= bufSel_nxt;
        end
    end

    genvar g;
    generate
        for (g = 0; g < CH_N; g++) begin : gCh
            logic             sync1_r;
            logic             sync2_r;
            logic             prev_r;
            logic             flag_r;
            logic             flag_nxt;
            logic             level_r;
            logic             level_nxt;
            logic             pinOut_r;
            logic             pinOut_nxt;
            logic             pinOeN_r;
            logic             pinOeN_nxt;
            logic [CNT_W-1:0] reg_nxt;
            logic [CNT_W-1:0] cmpValue;
            logic [SEL_W-1:0] sel;
            logic             enabled;
            logic             rise;
            logic             fall;
            logic             capture;
            logic             match;
            logic             freed;

            assign sel = chEdgeLevelSel[g*2 +: 2];
            // Channel one serves as buffer when the pair runs buffered PWM.
            assign freed   = bufferedPwm && (g != CH_LEAD);
            assign enabled = (sel != SEL_PORT) && !freed;
            assign chValue[g*16 +: 16] = chReg_r[g];
            assign chFlag[g]    = flag_r;
            assign chPinOut[g]  = pinOut_r;
            assign chPinOe_n[g] = pinOeN_r;

            always_comb begin
                rise = sync2_r && !prev_r;
                fall = !sync2_r && prev_r;
                capture = enabled && !chCompareMode[g] && !bufferedPwm
                    && ((sel == SEL_RISE && rise)
                     || (sel == SEL_FALL && fall)
                     || (sel == SEL_ANY && (rise || fall)));
                if (bufferedPwm && g == CH_LEAD) begin
                    cmpValue = bufSel_r ? chReg_r[1] : chReg_r[0];
                end else begin
                    cmpValue = chReg_r[g];
                end
                match = enabled && (chCompareMode[g] || bufferedPwm)
                        && tickDone_r && (count_r == cmpValue);
            end

            always_comb begin
                reg_nxt    = chReg_r[g];
                flag_nxt   = flag_r;
                level_nxt  = level_r;
                if (chValueWrite[g]) begin
                    reg_nxt = chValueIn[g*16 +: 16];
                end
                if (capture) begin
                    reg_nxt = count_r;
                end
                if (chFlagClear[g]) begin
                    flag_nxt = 1'b0;
                end
                if (capture || match) begin
                    flag_nxt = 1'b1;
                end
                if (match && !chMaxDuty[g]) begin
                    case (sel)
                        SEL_TOGGLE: begin
                            level_nxt = !level_r;
                        end
                        SEL_CLEAR: begin
                            level_nxt = 1'b0;
                        end
                        default: begin
                            level_nxt = 1'b1;
                        end
                    endcase
                end
                if (ovfEvent_r && chToggleOnOverflow[g]) begin
                    level_nxt = !level_nxt;
                end
                if (chMaxDuty[g]) begin
                    level_nxt = 1'b1;
                end
                if (enabled && (chCompareMode[g] || bufferedPwm)) begin
                    pinOut_nxt = level_nxt;
                    pinOeN_nxt = 1'b0;
                end else if (enabled) begin
                    pinOut_nxt = 1'b0;
                    pinOeN_nxt = 1'b1;
                end else begin
                    pinOut_nxt = portOut[g];
                    pinOeN_nxt = portOe_n[g];
                end
            end

            // Channel value register keeps no reset value.
            always_ff @(posedge ref_clk) begin
                chReg_r[g] <= reg_nxt;
            end
            always_ff @(posedge ref_clk) begin
                if (rst) begin
                    sync1_r  <= 1'b0;
                    sync2_r  <= 1'b0;
                    prev_r   <= 1'b0;
                    flag_r   <= FLAG_RESET;
                    level_r  <= 1'b0;
                    pinOut_r <= 1'b0;
                    pinOeN_r <= 1'b1;
                end else begin
                    sync1_r  <= chPinIn[g];
                    sync2_r  <= sync1_r;
                    prev_r   <= sync2_r;
                    flag_r   <= flag_nxt;
                    level_r  <= level_nxt;
                    pinOut_r <= pinOut_nxt;
                    pinOeN_r <= pinOeN_nxt;
                end
            end
        end
    endgenerate
endmodule
`default_nettype wire

// ### tct_core_assertions.sv
/*
 * Port checker for the two-channel timer core.
 * Assumes it is bound onto tct_core and that the core runs on one clock.
 */
`timescale 1ns/1ps
`default_nettype none
module tct_core_checker
    import tct_pkg::*;
(
    input wire logic                         ref_clk,
    input wire logic                         rst,
    input wire logic                         counterHalt,
    input wire logic                         counterClear,
    input wire logic [tct_pkg::PS_W-1:0]     prescaleSel,
    input wire logic                         overflowIrqEnable,
    input wire logic [tct_pkg::CNT_W-1:0]    counterValue,
    input wire logic [tct_pkg::BYTE_W-1:0]   wrapValueHigh,
    input wire logic [tct_pkg::BYTE_W-1:0]   wrapValueLow,
    input wire logic                         overflowFlag,
    input wire logic                         overflowIrq,
    input wire logic [tct_pkg::CH_N-1:0]     chCompareMode,
    input wire logic [tct_pkg::CH_N*2-1:0]   chEdgeLevelSel,
    input wire logic [tct_pkg::CH_N*16-1:0]  chValue,
    input wire logic [tct_pkg::CH_N-1:0]     chFlag,
    input wire logic [tct_pkg::CH_N-1:0]     portOut,
    input wire logic [tct_pkg::CH_N-1:0]     portOe_n,
    input wire logic [tct_pkg::CH_N-1:0]     chPinOut,
    input wire logic [tct_pkg::CH_N-1:0]     chPinOe_n
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    wire logic [CNT_W-1:0] wrapNow = {wrapValueHigh, wrapValueLow};
    sequence s_run; !counterHalt && !counterClear && prescaleSel == 3'h0;
    endsequence
    sequence s_atWrap; s_run ##0 counterValue == wrapNow; endsequence
    sequence s_wrapped; counterValue == CNT_RESET && overflowFlag; endsequence
    property p_reset; disable iff (1'b0) rst |=> counterValue == CNT_RESET
        && wrapNow == 16'hFFFF && !overflowFlag && chPinOe_n == 2'h3;
    endproperty
    property p_count; s_run ##0 counterValue != wrapNow |=>
        counterValue == $past(counterValue) + 16'h0001; endproperty
    property p_wrap; s_atWrap |=> s_wrapped; endproperty
    property p_stop; (counterHalt || prescaleSel == 3'h7) && !counterClear
        |=> $stable(counterValue); endproperty
    property p_clear; counterClear |=> counterValue == CNT_RESET; endproperty
    property p_irq; 1'b1 |=>
        overflowIrq == (overflowFlag && $past(overflowIrqEnable)); endproperty
    property p_capture; $rose(chFlag[0]) && !$past(chCompareMode[0])
        |-> chValue[15:0] == $past(counterValue); endproperty
    property p_capOe; !chCompareMode[0] && chEdgeLevelSel[1:0] != SEL_PORT
        |=> chPinOe_n[0]; endproperty
    property p_port; chEdgeLevelSel[3:2] == SEL_PORT |=> chPinOut[1] ==
        $past(portOut[1]) && chPinOe_n[1] == $past(portOe_n[1]); endproperty
    property p_cmpDrive; (chCompareMode[0] && chEdgeLevelSel[1:0] != SEL_PORT)
        [*2] |-> !chPinOe_n[0]; endproperty
    a_reset: assert property (p_reset) else $error("reset wrong");
    a_count: assert property (p_count) else $error("count step wrong");
    a_wrap: assert property (p_wrap) else $error("wrap wrong");
    a_stop: assert property (p_stop) else $error("counter moved");
    a_clear: assert property (p_clear) else $error("clear failed");
    a_irq: assert property (p_irq) else $error("irq wrong");
    a_capture: assert property (p_capture) else $error("capture");
    a_capOe: assert property (p_capOe) else $error("capture drives");
    a_port: assert property (p_port) else $error("port mux wrong");
    a_cmpDrive: assert property (p_cmpDrive) else $error("no drive");
endmodule
`default_nettype wire

// ### tct_pin_agent.sv
/*
 * External signal source on the two timer channel pins.
 * Assumes the bench sets the level it wants while the core lets go.
 */
`timescale 1ns/1ps
`default_nettype none
module tct_pin_agent (
    input  wire logic [1:0] drive,
    input  wire logic [1:0] pinOut,
    input  wire logic [1:0] pinOe_n,
    output logic      [1:0] pinIn
);
    // The core wins the wire whenever its enable is low.
    assign pinIn = (~pinOe_n & pinOut) | (pinOe_n & drive);
endmodule
`default_nettype wire

// ### tct_core_bench.sv
/*
 * Self-checking bench for the timer core with a pin agent and checker.
 * Assumes the package, core, agent and checker are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
module tct_core_bench;
    import tct_pkg::*;
    logic ref_clk = 1'b0, rst = 1'b1, counterHalt = 1'b1, counterClear = 1'b0;
    logic overflowIrqEnable = 1'b1, overflowFlagClear = 1'b0;
    logic wrapValueHighWrite = 1'b0, wrapValueLowWrite = 1'b0;
    logic bufferedPwm = 1'b0, counterHaltBit, overflowFlag, overflowIrq;
    logic [2:0] prescaleSel = 3'h0;
    logic [7:0] wrapValueHighIn = 8'h00, wrapValueLowIn = 8'h00;
    logic [7:0] wrapValueHigh, wrapValueLow;
    logic [1:0] chCompareMode = 2'h0, chToggleOnOverflow = 2'h0;
    logic [1:0] chMaxDuty = 2'h0, chValueWrite = 2'h0, chFlagClear = 2'h0;
    logic [1:0] portOut = 2'h0, portOe_n = 2'h2, drive = 2'h0, flagSeen = 2'h0;
    logic [1:0] chPinIn, chFlag, chPinOut, chPinOe_n;
    logic [3:0] chEdgeLevelSel = 4'h0;
    logic [31:0] chValueIn = 32'h0, chValue;
    logic [15:0] counterValue;
    logic [16:0] expQ[$];
    logic [16:0] note;
    int checks = 0, num_errors = 0, seed = 32'hF61BFE07;
    tct_core dut (.ref_clk, .rst, .counterHalt, .counterClear, .prescaleSel,
        .overflowIrqEnable, .overflowFlagClear, .wrapValueHighIn,
        .wrapValueHighWrite, .wrapValueLowIn, .wrapValueLowWrite,
        .counterValue, .wrapValueHigh, .wrapValueLow, .counterHaltBit,
        .overflowFlag, .overflowIrq, .bufferedPwm, .chCompareMode,
        .chEdgeLevelSel, .chToggleOnOverflow, .chMaxDuty, .chValueIn,
        .chValueWrite, .chFlagClear, .chValue, .chFlag, .portOut, .portOe_n,
        .chPinIn, .chPinOut, .chPinOe_n);
    tct_pin_agent agent (.drive, .pinOut(chPinOut), .pinOe_n(chPinOe_n),
        .pinIn(chPinIn));
    initial forever #5 ref_clk = ~ref_clk;
    task automatic chk(input logic [16:0] got, input logic [16:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    task automatic start;
        tick(1);
        counterClear <= 1'b1;
        tick(1);
        counterClear <= 1'b0;
        counterHalt <= 1'b0;
    endtask
    task automatic run(input int n);
        start();
        tick(n);
        counterHalt <= 1'b1;
        @(negedge ref_clk);
    endtask
    task automatic capt(input int g, input logic [1:0] sel, input logic from,
                        input logic hit);
        int p;
        p = 5 + ($unsigned($random(seed)) % 16);
        tick(1);
        drive[g] <= from;
        chEdgeLevelSel[2*g +: 2] <= SEL_PORT;
        tick(4);
        chCompareMode[g] <= 1'b0;
        chEdgeLevelSel[2*g +: 2] <= sel;
        chFlagClear[g] <= 1'b1;
        tick(1);
        chFlagClear[g] <= 1'b0;
        start();
        tick(p);
        drive[g] <= ~from;
        if (hit) expQ.push_back({g[0], 16'(p + 2)});
        tick(8);
        counterHalt <= 1'b1;
        @(negedge ref_clk);
        chk(chFlag[g], hit);
    endtask
    task automatic cmpr(input logic [1:0] sel, input logic lvl);
        logic [15:0] v;
        v = 16'h0008 + 16'($unsigned($random(seed)) % 32);
        tick(1);
        chCompareMode[0] <= 1'b1;
        chEdgeLevelSel[1:0] <= sel;
        chValueIn[15:0] <= v;
        chValueWrite[0] <= 1'b1;
        chFlagClear[0] <= 1'b1;
        tick(1);
        chValueWrite[0] <= 1'b0;
        chFlagClear[0] <= 1'b0;
        expQ.push_back({1'b0, v});
        run(int'(v) + 6);
        chk(chPinOut[0], lvl);
        chk(chPinOe_n[0], 1'b0);
    endtask
    task automatic conclude;
        $display("checks %0d num_errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    always @(negedge ref_clk) begin
        for (int g = 0; g < 2; g++) begin
            if (chFlag[g] === 1'b1 && flagSeen[g] !== 1'b1) begin
                note = (expQ.size() > 0) ? expQ.pop_front() : 17'h1FFFF;
                chk({g[0], chValue[16*g +: 16]}, note);
            end
        end
        flagSeen <= chFlag;
    end
    initial begin
        #50us;
        num_errors++;
        conclude();
    end
    initial begin
        tick(2);
        rst <= 1'b0;
        @(negedge ref_clk);
        chk(counterValue, 17'h0);
        chk({wrapValueHigh, wrapValueLow}, 17'hFFFF);
        chk({overflowFlag, overflowIrq, counterHaltBit}, 17'h1);
        for (int s = 0; s < 8; s++) begin
            tick(1);
            prescaleSel <= 3'(s);
            run(64);
            chk(counterValue, (s == 7) ? 17'h0 : 17'(64 >> s));
        end
        tick(1);
        prescaleSel <= 3'h0;
        portOe_n <= 2'h3;
        portOut <= 2'($random(seed));
        capt(0, SEL_RISE, 1'b0, 1'b1);
        capt(0, SEL_RISE, 1'b1, 1'b0);
        capt(1, SEL_FALL, 1'b1, 1'b1);
        capt(1, SEL_FALL, 1'b0, 1'b0);
        capt(0, SEL_ANY, 1'b0, 1'b1);
        capt(0, SEL_ANY, 1'b1, 1'b1);
        cmpr(SEL_SET, 1'b1);
        cmpr(SEL_CLEAR, 1'b0);
        cmpr(SEL_TOGGLE, 1'b1);
        tick(1);
        wrapValueLowIn <= 8'h05;
        wrapValueHighWrite <= 1'b1;
        wrapValueLowWrite <= 1'b1;
        chToggleOnOverflow[0] <= 1'b1;
        chValueIn[15:0] <= 16'h00FF;
        chValueWrite[0] <= 1'b1;
        tick(1);
        wrapValueHighWrite <= 1'b0;
        wrapValueLowWrite <= 1'b0;
        chValueWrite[0] <= 1'b0;
        run(18);
        tick(2);
        @(negedge ref_clk);
        chk({wrapValueHigh, wrapValueLow}, 17'h0005);
        chk(chPinOut[0], 1'b0);
        chk({overflowFlag, counterValue}, 17'h10000);
        chk(overflowIrq, 1'b1);
        tick(1);
        overflowFlagClear <= 1'b1;
        tick(1);
        overflowFlagClear <= 1'b0;
        @(negedge ref_clk);
        chk({overflowFlag, overflowIrq}, 17'h0);
        tick(1);
        bufferedPwm <= 1'b1;
        chEdgeLevelSel[1:0] <= SEL_CLEAR;
        chValueIn[31:16] <= 16'h0003;
        chValueWrite <= 2'h2;
        chFlagClear[0] <= 1'b1;
        expQ.push_back({1'b0, 16'h00FF});
        tick(1);
        chValueWrite <= 2'h0;
        chFlagClear[0] <= 1'b0;
        run(11);
        chk(chFlag[0], 1'b1);
        chk(chPinOut[0], 1'b0);
        tick(1);
        chMaxDuty[0] <= 1'b1;
        tick(2);
        @(negedge ref_clk);
        chk(chPinOut[0], 1'b1);
        chk(17'(expQ.size()), 17'h0);
        conclude();
    end
endmodule
bind tct_core tct_core_checker u_chk (.ref_clk, .rst, .counterHalt,
    .counterClear, .prescaleSel, .overflowIrqEnable, .counterValue,
    .wrapValueHigh, .wrapValueLow, .overflowFlag, .overflowIrq,
    .chCompareMode, .chEdgeLevelSel, .chValue, .chFlag, .portOut, .portOe_n,
    .chPinOut, .chPinOe_n);
`default_nettype wire
